//--- rtl/serial_port_ctrl.sv
// Serial port: control register, buffers, mode 0/UART sequencing
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "serial_port_cfg.svh"
module serial_port_ctrl
	import serial_port_pkg::*;
(
	input  wire logic       clk_in,       // 25 MHz oscillator clock
	input  wire logic       reset_in,     // Async reset, high
	input  wire logic [7:0] addr_in,      // Register byte address
	input  wire logic [7:0] wdata_in,     // Write data
	input  wire logic       wr_in,        // Write strobe
	input  wire logic       rd_in,        // Read strobe
	input  wire logic       bit_wr_in,    // Single-bit write strobe
	input  wire logic [7:0] bit_addr_in,  // Bit address for bit write
	input  wire logic       bit_val_in,   // Value for bit write
	output logic [7:0]      rdata_out,    // Read data, cycle after
	input  wire logic       t1_ovf_in,    // Timer 1 overflow pulse
	input  wire logic       rxd_in,       // Receive line level
	output logic            rxd_out,      // Mode 0 data out
	output logic            rxd_oe_out,   // Mode 0 data drive enable
	output logic            txd_out,      // Tx line / mode 0 clock
	output logic            irq_out       // Serial interrupt request
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0]  ctrl_ff;    // Control register
		logic [7:0]  baud_ff;    // Baud configuration
		logic [7:0]  rxbuf_ff;   // Receive buffer
		logic [7:0]  rdata_ff;   // Read data
		logic [3:0]  ph_ff;      // Phase in machine cycle
		sp_state_t   tx_st_ff;   // Transmit sequencer
		logic [8:0]  tsr_ff;     // Transmit shift register
		logic [3:0]  tcnt_ff;    // Tx sixteenth counter
		logic [3:0]  tbits_ff;   // Tx bit count
		logic        txd_ff;     // Tx line register
		sp_state_t   rx_st_ff;   // Receive sequencer
		logic [8:0]  rsr_ff;     // Receive shift register
		logic [3:0]  rcnt_ff;    // Rx sixteenth counter
		logic [3:0]  rbits_ff;   // Rx bit count
		logic [2:0]  smp_ff;     // Majority samples
		logic        rxo_ff;     // Mode 0 rx-line output
		logic        rxoe_ff;    // Mode 0 rx-line enable
		logic [1:0]  rxs_ff;     // Rx line synchroniser
		logic        rxp_ff;     // Previous synchronised rx level
	} sp_st_t;
	sp_st_t st_ff, nxt_st;

	sp_mode_t mode;              // Decoded mode
	logic     tick16;            // Sixteenth-bit tick
	logic     mc_end;            // Last phase of machine cycle
	logic     rx_s;              // Synchronised receive line
	logic     maj;               // Majority of three samples
	logic     wr_buf;            // Buffer write this cycle
	logic [7:0] ctrl_w;          // Control after software writes

	assign mode   = sp_mode_t'({st_ff.ctrl_ff[`SP_MODE_HI_POS],
	                            st_ff.ctrl_ff[`SP_MODE_LO_POS]});
	assign mc_end = (st_ff.ph_ff == `SP_MC_CYCLES - 4'd1);
	assign rx_s   = st_ff.rxs_ff[1];
	assign maj    = (st_ff.smp_ff[0] & st_ff.smp_ff[1]) |
	                (st_ff.smp_ff[1] & st_ff.smp_ff[2]) |
	                (st_ff.smp_ff[0] & st_ff.smp_ff[2]);
	assign wr_buf = wr_in && addr_in == `SP_BUF_ADDR;

	// ==========================================================
	// Bit-rate generator
	serial_baud_gen u_baud (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.mode_in     (mode),
		.doubler_in  (st_ff.baud_ff[`SP_DOUBLER_POS]),
		.int_baud_in (st_ff.baud_ff[`SP_INTBAUD_POS]),
		.t1_ovf_in   (t1_ovf_in),
		.tick16_out  (tick16)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		// Two-flop synchroniser on the receive pin
		nxt_st.rxs_ff = {st_ff.rxs_ff[0], rxd_in};
		// Last level, so a start needs a falling edge, not a low
		nxt_st.rxp_ff = rx_s;
		// Machine cycle phase counter, fosc/12 enable
		nxt_st.ph_ff = mc_end ? 4'd0 : st_ff.ph_ff + 4'd1;

		// Software writes to control: byte or bit-addressed
		ctrl_w = st_ff.ctrl_ff;
		if (wr_in && addr_in == `SP_CTRL_ADDR) begin
			ctrl_w = wdata_in;
		end
		if (bit_wr_in && bit_addr_in >= `SP_CTRL_BIT_LO &&
		    bit_addr_in <= `SP_CTRL_BIT_HI) begin
			ctrl_w[bit_addr_in[2:0]] = bit_val_in;
		end
		nxt_st.ctrl_ff = ctrl_w;
		if (wr_in && addr_in == `SP_BAUD_ADDR) begin
			nxt_st.baud_ff = wdata_in;
		end

		// Read port: buffer read returns receive side
		nxt_st.rdata_ff = 8'h00;
		if (rd_in) begin
			case (addr_in)
				`SP_CTRL_ADDR: nxt_st.rdata_ff = st_ff.ctrl_ff;
				`SP_BUF_ADDR:  nxt_st.rdata_ff = st_ff.rxbuf_ff;
				`SP_BAUD_ADDR: nxt_st.rdata_ff = st_ff.baud_ff;
				default:       nxt_st.rdata_ff = 8'h00;
			endcase
		end

		// ------------------------------------------------------
		// Transmit sequencer
		case (st_ff.tx_st_ff)
			ST_IDLE: begin
				if (wr_buf) begin
					// Load data; ninth is marker or tx ninth bit
					nxt_st.tsr_ff = {(mode == MODE_SHIFT) ? 1'b1 :
						st_ff.ctrl_ff[`SP_TX9_POS], wdata_in};
					nxt_st.tbits_ff = 4'd0;
					nxt_st.tcnt_ff  = 4'd0;
					nxt_st.tx_st_ff = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Mode 0 waits one machine cycle; UART to the next sixteenth tick
				if (mode == MODE_SHIFT && st_ff.ph_ff == 4'd0) begin
					// A whole machine cycle has begun since the write
					nxt_st.tcnt_ff = 4'd1;
				end
				if ((mode == MODE_SHIFT && mc_end &&
				     st_ff.tcnt_ff[0]) ||
				    (mode != MODE_SHIFT && tick16)) begin
					nxt_st.tx_st_ff = ST_SHIFT;
					if (mode != MODE_SHIFT) nxt_st.txd_ff = 1'b0;
				end
			end
			ST_SHIFT: begin
				if (mode == MODE_SHIFT) begin
					// Clock low mid-cycle, data LSB first
					nxt_st.txd_ff  = !(st_ff.ph_ff >= 4'd4 &&
					                   st_ff.ph_ff < 4'd10);
					nxt_st.rxoe_ff = 1'b1;
					nxt_st.rxo_ff  = st_ff.tsr_ff[0];
					if (mc_end) begin
						nxt_st.tsr_ff   = {1'b0, st_ff.tsr_ff[8:1]};
						nxt_st.tbits_ff = st_ff.tbits_ff + 4'd1;
						if (st_ff.tbits_ff == 4'd7) begin
							nxt_st.tx_st_ff = ST_IDLE;
							nxt_st.rxoe_ff  = 1'b0;
							nxt_st.ctrl_ff[`SP_TXDONE_POS] = 1'b1;
						end
					end
				end else if (tick16) begin
					nxt_st.tcnt_ff = st_ff.tcnt_ff + 4'd1;
					if (st_ff.tcnt_ff == `SP_OVS_DIV - 5'd1) begin
						nxt_st.tbits_ff = st_ff.tbits_ff + 4'd1;
						// Data bits follow the start bit
						nxt_st.txd_ff = st_ff.tsr_ff[0];
						nxt_st.tsr_ff = {1'b0, st_ff.tsr_ff[8:1]};
						if (st_ff.tbits_ff == ((mode == MODE_UART8) ?
						    4'd8 : 4'd9)) begin
							// Stop bit begins: flag done
							nxt_st.txd_ff = 1'b1;
							nxt_st.ctrl_ff[`SP_TXDONE_POS] = 1'b1;
							nxt_st.tx_st_ff = ST_IDLE;
						end
					end
				end
			end
			default: nxt_st.tx_st_ff = ST_IDLE;
		endcase
		if (st_ff.tx_st_ff != ST_SHIFT) begin
			nxt_st.txd_ff = (st_ff.tx_st_ff == ST_WAIT &&
				mode != MODE_SHIFT && tick16) ? 1'b0 : 1'b1;
		end

		// ------------------------------------------------------
		// Receive sequencer
		case (st_ff.rx_st_ff)
			ST_IDLE: begin
				nxt_st.rcnt_ff  = 4'd0;
				nxt_st.rbits_ff = 4'd0;
				if (st_ff.ctrl_ff[`SP_RXEN_POS]) begin
					if (mode == MODE_SHIFT &&
					    !st_ff.ctrl_ff[`SP_RXDONE_POS] && mc_end &&
					    st_ff.tx_st_ff == ST_IDLE) begin
						nxt_st.rx_st_ff = ST_SHIFT;
					end else if (mode != MODE_SHIFT && st_ff.rxp_ff &&
					             !rx_s) begin
						nxt_st.rx_st_ff = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				// Check start bit at its middle
				if (tick16) begin
					nxt_st.rcnt_ff = st_ff.rcnt_ff + 4'd1;
					nxt_st.smp_ff  = {st_ff.smp_ff[1:0], rx_s};
					if (st_ff.rcnt_ff == 4'd9) begin
						nxt_st.rx_st_ff = maj ? ST_IDLE : ST_SHIFT;
					end
				end
			end
			ST_SHIFT: begin
				if (mode == MODE_SHIFT) begin
					nxt_st.txd_ff = !(st_ff.ph_ff >= 4'd4 &&
					                  st_ff.ph_ff < 4'd10);
					if (mc_end) begin
						nxt_st.rsr_ff   = {rx_s, st_ff.rsr_ff[8:1]};
						nxt_st.rbits_ff = st_ff.rbits_ff + 4'd1;
						if (st_ff.rbits_ff == 4'd7) begin
							nxt_st.rxbuf_ff = {rx_s, st_ff.rsr_ff[8:2]};
							nxt_st.ctrl_ff[`SP_RXDONE_POS] = 1'b1;
							nxt_st.rx_st_ff = ST_IDLE;
						end
					end
				end else if (tick16) begin
					nxt_st.rcnt_ff = st_ff.rcnt_ff + 4'd1;
					nxt_st.smp_ff  = {st_ff.smp_ff[1:0], rx_s};
					if (st_ff.rcnt_ff == 4'd9) begin
						nxt_st.rbits_ff = st_ff.rbits_ff + 4'd1;
						nxt_st.rsr_ff   = {maj, st_ff.rsr_ff[8:1]};
						// Middle of stop bit, after the ninth bit in 9-bit modes
						if (st_ff.rbits_ff == ((mode == MODE_UART8) ?
						    4'd8 : 4'd9)) begin
							nxt_st.rx_st_ff = ST_IDLE;
							if (!st_ff.ctrl_ff[`SP_RXDONE_POS] &&
							    (!st_ff.ctrl_ff[`SP_FILT_POS] ||
							     (mode == MODE_UART8 ? maj :
							      st_ff.rsr_ff[8]))) begin
								nxt_st.rxbuf_ff = (mode == MODE_UART8) ?
									st_ff.rsr_ff[8:1] : st_ff.rsr_ff[7:0];
								// Ninth or stop bit captured
								nxt_st.ctrl_ff[`SP_RX9_POS] =
									(mode == MODE_UART8) ? maj :
									st_ff.rsr_ff[8];
								nxt_st.ctrl_ff[`SP_RXDONE_POS] = 1'b1;
							end
						end
					end
				end
			end
			default: nxt_st.rx_st_ff = ST_IDLE;
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_ff          <= '0;
			st_ff.ctrl_ff  <= `SP_CTRL_RESET;
			st_ff.baud_ff  <= `SP_BAUD_RESET;
			st_ff.txd_ff   <= 1'b1;
			st_ff.rxs_ff   <= 2'b11;
			st_ff.rxp_ff   <= 1'b1;
			st_ff.smp_ff   <= 3'b111;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata_out  = st_ff.rdata_ff;
	assign txd_out    = st_ff.txd_ff;
	assign rxd_out    = st_ff.rxo_ff;
	assign rxd_oe_out = st_ff.rxoe_ff;
	assign irq_out    = st_ff.ctrl_ff[`SP_TXDONE_POS] |
	                    st_ff.ctrl_ff[`SP_RXDONE_POS];
endmodule

//--- rtl/serial_port_cfg.svh
// Constants of the serial port: offsets, bit positions, resets, counts
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// ==========================================================
// Register byte offsets and control register bit-address range
`define SP_CTRL_ADDR      8'h98
`define SP_BUF_ADDR       8'h99
`define SP_BAUD_ADDR      8'h9a
`define SP_CTRL_BIT_LO    8'h98
`define SP_CTRL_BIT_HI    8'h9f

// ==========================================================
// Control register bit positions
`define SP_RXDONE_POS     0
`define SP_TXDONE_POS     1
`define SP_RX9_POS        2
`define SP_TX9_POS        3
`define SP_RXEN_POS       4
`define SP_FILT_POS       5
`define SP_MODE_LO_POS    6
`define SP_MODE_HI_POS    7

// Baud configuration register bit positions
`define SP_DOUBLER_POS    0
`define SP_INTBAUD_POS    1
`define SP_T1SRC_POS      2

// ==========================================================
// Reset values
`define SP_CTRL_RESET     8'h00
`define SP_BAUD_RESET     8'h00
`define SP_RELOAD_RESET   8'h00

// ==========================================================
// Timing counts in oscillator cycles; SP_OVS_DIV in ticks per bit
`define SP_MC_CYCLES      4'd12
`define SP_M2_DIV         12'd64
`define SP_INT_DIV        12'd2500
`define SP_OVS_DIV        5'd16

`endif

//--- rtl/serial_port_pkg.sv
// Types of the serial port
package serial_port_pkg;
	// Operating mode from the two mode bits
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_UART8 = 2'b01,
		MODE_UART9F = 2'b10,
		MODE_UART9V = 2'b11
	} sp_mode_t;
	// Link sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_SHIFT = 2'b10
	} sp_state_t;
endpackage

//--- rtl/serial_baud_gen.sv
// Bit-rate tick generator: sixteenth-bit ticks for UART modes
`timescale 1ns/10ps
`include "serial_port_cfg.svh"
module serial_baud_gen
	import serial_port_pkg::*;
(
	input  wire logic       clk_in,      // Oscillator clock
	input  wire logic       reset_in,    // Async reset, high
	input  wire logic [1:0] mode_in,     // Operating mode
	input  wire logic       doubler_in,  // Baud doubling bit
	input  wire logic       int_baud_in, // Internal generator select
	input  wire logic       t1_ovf_in,   // Timer 1 overflow pulse
	output logic            tick16_out   // One sixteenth of a bit
);
	// Whole state in one struct
	typedef struct packed {
		logic [11:0] div_ff;   // Oscillator divider
		logic        half_ff;  // Halving stage for undoubled rate
		logic        tick_ff;  // Registered tick
	} bg_state_t;
	bg_state_t st_ff, nxt_st;
	logic [11:0] limit;        // Divider terminal count
	logic        src_pulse;    // Raw pulse before halving

	// Pick source and divide; the doubler bypasses the /2 stage
	always_comb begin
		nxt_st = st_ff;
		// Mode 2 gives 16 ticks per bit at fosc/64, or at fosc/32 with the doubler
		limit = (mode_in == MODE_UART9F) ? (`SP_M2_DIV >> 1) / 12'd16 :
			// Internal generator at doubled rate
			`SP_INT_DIV / 12'd32;
		src_pulse = 1'b0;
		if (mode_in == MODE_UART9F || int_baud_in) begin
			if (st_ff.div_ff >= limit - 12'd1) begin
				nxt_st.div_ff = 12'd0;
				src_pulse = 1'b1;
			end else begin
				nxt_st.div_ff = st_ff.div_ff + 12'd1;
			end
		end else begin
			// Timer 1 overflow rate over 32, times doubler
			nxt_st.div_ff = 12'd0;
			src_pulse = t1_ovf_in;
		end
		nxt_st.tick_ff = 1'b0;
		if (src_pulse) begin
			if (doubler_in) begin
				nxt_st.tick_ff = 1'b1;
			end else begin
				nxt_st.half_ff = ~st_ff.half_ff;
				nxt_st.tick_ff = st_ff.half_ff;
			end
		end
	end

	// Register state
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick16_out = st_ff.tick_ff;
endmodule

//--- testbench/serial_port_ctrl_chk.sv
// Concurrent checks on the serial port control block ports
`timescale 1ns/10ps
module serial_port_chk
	import serial_port_pkg::*;
(
	input wire logic       clk_in,     // Oscillator clock
	input wire logic       reset_in,   // Async reset, high
	input wire logic [7:0] addr_in,    // Register address
	input wire logic [7:0] wdata_in,   // Write data
	input wire logic       wr_in,      // Write strobe
	input wire logic       rd_in,      // Read strobe
	input wire logic       bit_wr_in,  // Bit write strobe
	input wire logic [7:0] rdata_out,  // Read data
	input wire logic       rxd_oe_out, // Mode 0 data enable
	input wire logic       txd_out,    // Tx line or shift clock
	input wire logic       irq_out     // Interrupt request
);
	// ==========================================================
	// Helper logic
	logic [1:0] mode_ff; // Mode bits last written by byte
	logic       sw_wr;   // Any software write this cycle
	assign sw_wr = wr_in || bit_wr_in;
	// Shadow of the mode field, to know when mode 0 rules apply
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			mode_ff <= 2'b00;
		else if (wr_in && addr_in == 8'h98)
			mode_ff <= wdata_in[7:6];
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ==========================================================
	// Assertions
	rd_idle_a: assert property (
		!rd_in |=> rdata_out == 8'h00) else $error("data without read");
	unmapped_rd_a: assert property (
		rd_in && (addr_in < 8'h98 || addr_in > 8'h9a)
		|=> rdata_out == 8'h00) else $error("unmapped read not zero");
	reset_out_a: assert property (
		$fell(reset_in) |-> txd_out && !irq_out && !rxd_oe_out)
		else $error("outputs wrong after reset");
	m0_start_a: assert property (
		wr_in && addr_in == 8'h99 && mode_ff == 2'b00 && !rxd_oe_out
		|=> (!rxd_oe_out)[*8] ##[6:17] $rose(rxd_oe_out))
		else $error("mode 0 send not one machine cycle later");
	m0_len_a: assert property (
		$rose(rxd_oe_out) |-> rxd_oe_out[*8])
		else $error("mode 0 send too short");
	m0_clk_a: assert property (
		$fell(txd_out) && rxd_oe_out |=> (!$fell(txd_out))[*8])
		else $error("shift clock too fast");
	m0_done_a: assert property (
		$fell(rxd_oe_out) && mode_ff == 2'b00 |-> ##[0:24] irq_out)
		else $error("tx done missing after mode 0 send");
	irq_clear_a: assert property (
		$fell(irq_out) |-> $past(sw_wr) || $past(sw_wr, 2))
		else $error("interrupt dropped without software clear");
endmodule
bind serial_port_ctrl serial_port_chk u_serial_port_chk (
	.clk_in     (clk_in),
	.reset_in   (reset_in),
	.addr_in    (addr_in),
	.wdata_in   (wdata_in),
	.wr_in      (wr_in),
	.rd_in      (rd_in),
	.bit_wr_in  (bit_wr_in),
	.rdata_out  (rdata_out),
	.rxd_oe_out (rxd_oe_out),
	.txd_out    (txd_out),
	.irq_out    (irq_out)
);

//--- testbench/serial_partner.sv
// Far-side serial partner: frame sender and frame/shift capture
`timescale 1ns/10ps
module serial_partner (
	input  wire logic clk_in,     // Oscillator clock
	input  wire logic txd_in,     // Device tx line or shift clock
	input  wire logic data_in,    // Device mode 0 data
	input  wire logic data_oe_in, // Device mode 0 drive enable
	output logic      line_out    // Level put on the rx line
);
	// Idle line rests high, as on a pulled-up wire
	initial begin
		line_out = 1'b1;
	end
	// Send n bits LSB first, bt clocks each, then release high
	task automatic send(input logic [10:0] f, input int n, bt);
		for (int i = 0; i < n; i++) begin
			line_out <= f[i];
			repeat (bt) @(posedge clk_in);
		end
		line_out <= 1'b1;
	endtask
	// Take 8 mode 0 bits on rising shift clock, LSB first
	task automatic shift_in(output logic [7:0] d);
		d = 8'h00;
		for (int i = 0; i < 8; i++) begin
			@(posedge txd_in iff data_oe_in);
			d = {data_in, d[7:1]};
		end
	endtask
	// Sample a UART frame in mid-bit, start bit included
	task automatic frame_in(input int n, bt, output logic [10:0] f);
		f = 11'h000;
		@(negedge txd_in);
		repeat (bt / 2) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			f[i] = txd_in;
			repeat (bt) @(posedge clk_in);
		end
	endtask
endmodule

//--- testbench/serial_port_ctrl_bench.sv
// Self-checking bench of the serial port control block
`timescale 1ns/10ps
module serial_port_ctrl_bench
	import serial_port_pkg::*;
;
	logic       clk_in, reset_in, wr_in, rd_in, bit_wr_in, bit_val_in;
	logic       t1_ovf_in, line, rxd_out, rxd_oe_out, txd_out, irq_out;
	logic [7:0] addr_in, wdata_in, bit_addr_in, rdata_out;
	logic [1:0] ovf_cnt;
	int         n_mismatch, comparisons, cyc;
	wire        rxd_in = rxd_oe_out ? rxd_out : line;
	// ==========================================================
	// Instances
	serial_port_ctrl u_serial_port_ctrl (
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.bit_wr_in(bit_wr_in), .bit_addr_in(bit_addr_in),
		.bit_val_in(bit_val_in), .rdata_out(rdata_out),
		.t1_ovf_in(t1_ovf_in), .rxd_in(rxd_in), .rxd_out(rxd_out),
		.rxd_oe_out(rxd_oe_out), .txd_out(txd_out), .irq_out(irq_out));
	serial_partner u_serial_partner (.clk_in(clk_in), .txd_in(txd_out),
		.data_in(rxd_out), .data_oe_in(rxd_oe_out), .line_out(line));
	// Clock at 40 ns period
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Timer 1 overflow every fourth clock; run length guard
	// Timer 1 raises no interrupt here
	always @(posedge clk_in) begin
		ovf_cnt <= ovf_cnt + 2'd1;
		t1_ovf_in <= (ovf_cnt == 2'd3);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic bw(input logic [7:0] a, input logic v);
		bit_addr_in <= a;
		bit_val_in <= v;
		bit_wr_in <= 1'b1;
		@(posedge clk_in);
		bit_wr_in <= 1'b0;
		@(posedge clk_in);
	endtask
	// Read, then compare the data standing in the next cycle
	task automatic rdc(input logic [7:0] a, exp);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		check(rdata_out, exp);
		@(posedge clk_in);
	endtask
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq_out !== 1'b1; i++)
			@(posedge clk_in);
		check(8'(irq_out), 8'h01);
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic s_regs();
		logic [7:0] e;
		e = 8'h00;
		check(8'(txd_out), 8'h01);
		rdc(8'h98, 8'h00);
		rdc(8'h9a, 8'h00);
		rdc(8'h9b, 8'h00);
		for (int i = 7; i >= 2; i--) begin
			bw(8'h98 + i[7:0], 1'b1);
			e[i] = 1'b1;
			rdc(8'h98, e);
		end
		wr(8'h98, 8'h00);
		rdc(8'h98, 8'h00);
	endtask
	task automatic s_m0tx();
		logic [7:0] d;
		wr(8'h98, 8'h00);
		fork
			u_serial_partner.shift_in(d);
			wr(8'h99, 8'ha5);
		join
		@(posedge clk_in);
		check(d, 8'ha5);
		wait_irq(40);
		rdc(8'h98, 8'h02);
		bw(8'h99, 1'b0);
		repeat (2) @(posedge clk_in);
		check(8'(irq_out), 8'h00);
	endtask
	task automatic s_m2rx();
		wr(8'h9a, 8'h00);
		wr(8'h98, 8'hb0);
		u_serial_partner.send({2'b10, 8'h3c, 1'b0}, 11, 64);
		repeat (40) @(posedge clk_in);
		rdc(8'h98, 8'hb0);
		u_serial_partner.send({2'b11, 8'h5a, 1'b0}, 11, 64);
		repeat (40) @(posedge clk_in);
		rdc(8'h98, 8'hb5);
		rdc(8'h99, 8'h5a);
		wr(8'h98, 8'h80);
	endtask
	task automatic s_m1rx();
		wr(8'h9a, 8'h05);
		wr(8'h98, 8'h70);
		u_serial_partner.send({2'b10, 8'h81, 1'b0}, 10, 64);
		repeat (40) @(posedge clk_in);
		rdc(8'h98, 8'h70);
		wr(8'h98, 8'h50);
		u_serial_partner.send({2'b11, 8'hc3, 1'b0}, 10, 64);
		repeat (40) @(posedge clk_in);
		rdc(8'h98, 8'h55);
		rdc(8'h99, 8'hc3);
		wr(8'h98, 8'h00);
	endtask
	task automatic s_m2tx();
		logic [10:0] f;
		wr(8'h9a, 8'h01);
		wr(8'h98, 8'h88);
		fork
			u_serial_partner.frame_in(11, 32, f);
			wr(8'h99, 8'h96);
		join
		@(posedge clk_in);
		check(f[8:1], 8'h96);
		check({5'h00, f[10:9], f[0]}, 8'h06);
		wait_irq(10);
		rdc(8'h98, 8'h8a);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		reset_in = 1'b1;
		{wr_in, rd_in, bit_wr_in, bit_val_in, t1_ovf_in} = 5'h00;
		{addr_in, wdata_in, bit_addr_in} = 24'h000000;
		{ovf_cnt, n_mismatch, comparisons, cyc} = '0;
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		s_regs();
		s_m0tx();
		s_m2rx();
		s_m1rx();
		s_m2tx();
		end_of_test();
	end
endmodule
